// ===== core/ns_conv_defines.svh
// Constants for the namespace and register-convention block
// -----------------------------------------------------------------------------
// What this block does
// - A single-port, single-function subsystem reports its controller as function number 0.
// - All controllers sharing a namespace use one identical namespace handle for it.
// - Each controller presents its own distinct controller identification data.
// - Sharing controllers return byte-identical namespace identification data for one namespace.
// - Shared-namespace atomicity follows the receiving controller's own write granule.
// - A port reset touches only that port's controller, nothing shared.
// - Reserved bits and reserved registers always read as zero.
// - Write-one-clear bits clear on a written one; a written zero changes nothing.
// - Write-one-set bits set on a written one; a written zero changes nothing.
// - Optionally writable or clearable fields act read-only when unsupported.
// - Zero-based fields hold value minus one; 0h means one.
// - One kilobyte unit equals 1024 bytes in every size calculation.
// - String fields hold only printable codes 20h through 7Eh.
// - Strings start at the lowest byte, left aligned, padded with 20h.
// - Admin submission and completion queues both use identifier 0.
// - Admin submission queue completions go only to the admin completion queue.
// - A namespace handle of all ones addresses every namespace.
// - Handle zero or above the namespace count is invalid.
// -----------------------------------------------------------------------------
`ifndef NS_CONV_DEFINES_SVH
`define NS_CONV_DEFINES_SVH

`define NSC_NPORT 2
`define NSC_CTRL_RW_MASK 32'h0000_00FF
`define NSC_CTRL_SET_MASK 32'h0000_0F00
`define NSC_CTRL_RST 32'h0000_0004
`define NSC_STAT_CLR_MASK 32'h0000_000F
`define NSC_AQA_MASK 32'h0FFF_0FFF
`define NSC_AQA_CQ_LSB 16
`define NSC_ID_PORT_LSB 8
`define NSC_ADMIN_QID 16'h0000
`define NSC_PCI_FUNC 8'h00
`define NSC_NS_ALL 32'hFFFF_FFFF
`define NSC_NS_NONE 32'h0000_0000
`define NSC_NS_MAX 32'h0000_0003
`define NSC_KB_SHIFT 10
`define NSC_ASCII_LO 8'h20
`define NSC_ASCII_HI 8'h7E
`define NSC_ASCII_PAD 8'h20
`define NSC_STR_LEN 8
`define NSC_IDENT_AW 4
`define NSC_IDENT_DEPTH 16

`endif

// ===== core/ns_conv_pkg.sv
// Types shared by the namespace and register-convention block
`include "ns_conv_defines.svh"

package ns_conv_pkg;

   // -----------------------------------------------------------------------------
   // Field selection and namespace handle classes
   // -----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_CTRL = 2'b00,
      SEL_STAT = 2'b01,
      SEL_AQA = 2'b10,
      SEL_IDENT = 2'b11
   } field_sel_e;

   typedef enum logic [1:0] {
      NS_INVALID = 2'b00,
      NS_SINGLE = 2'b01,
      NS_ALL = 2'b10
   } ns_kind_e;

   // -----------------------------------------------------------------------------
   // Whole state of the top module
   // -----------------------------------------------------------------------------
   typedef struct packed {
      logic [`NSC_NPORT-1:0][31:0] ctrl;
      logic [`NSC_NPORT-1:0][31:0] stat;
      logic [`NSC_NPORT-1:0][31:0] aqa;
      logic [`NSC_NPORT-1:0][31:0] rdata;
      logic [`NSC_NPORT-1:0][1:0] ns_kind;
      logic [`NSC_NPORT-1:0] ns_ack;
      logic [`NSC_NPORT-1:0][15:0] cpl_qid;
      logic [`NSC_NPORT-1:0][12:0] atomic_blocks;
      logic [63:0] model;
   } top_state_s;

   typedef struct packed {
      logic [`NSC_NPORT-1:0][31:0] rdata;
   } mem_state_s;

endpackage : ns_conv_pkg

// ===== core/ns_ident_mem.sv
// Shared namespace identification store with one registered read port per controller
`timescale 1ns/10ps
`include "ns_conv_defines.svh"

module ns_ident_mem (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Platform fill port
   input wire logic i_we,
   input wire logic [`NSC_IDENT_AW-1:0] i_waddr,
   input wire logic [31:0] i_wdata,
   // Controller read ports
   input wire logic [`NSC_NPORT-1:0] i_re,
   input wire logic [`NSC_NPORT-1:0][`NSC_IDENT_AW-1:0] i_raddr,
   output logic [`NSC_NPORT-1:0][31:0] o_rdata
);

   logic [31:0] mem [`NSC_IDENT_DEPTH];
   ns_conv_pkg::mem_state_s st;
   ns_conv_pkg::mem_state_s next_st;

   // -----------------------------------------------------------------------------
   // Storage survives every reset so a port reset never disturbs shared data
   // -----------------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   // One array read by every port: all controllers see the same bytes
   always_comb begin
      next_st = st;
      for (int p = 0; p < `NSC_NPORT; p++) begin
         if (i_srst) begin
            next_st.rdata[p] = 32'h0000_0000;
         end else if (i_re[p]) begin
            next_st.rdata[p] = mem[i_raddr[p]];
         end else begin
            next_st.rdata[p] = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      st <= next_st;
   end

   assign o_rdata = st.rdata;

endmodule : ns_ident_mem

// ===== core/ascii_pad.sv
// Cleans and pads a fixed-length ASCII string field
`timescale 1ns/10ps
`include "ns_conv_defines.svh"

module ascii_pad (
   // Raw string, first character in the lowest byte
   input wire logic [8*`NSC_STR_LEN-1:0] i_raw,
   input wire logic [3:0] i_len,
   // Cleaned string
   output logic [8*`NSC_STR_LEN-1:0] o_clean
);

   // -----------------------------------------------------------------------------
   // Byte cleaning
   // -----------------------------------------------------------------------------
   function automatic logic [7:0] clean_byte(input logic [7:0] c, input logic used);
      if (!used) begin
         clean_byte = `NSC_ASCII_PAD;
      end else if (c < `NSC_ASCII_LO || c > `NSC_ASCII_HI) begin
         clean_byte = `NSC_ASCII_PAD;
      end else begin
         clean_byte = c;
      end
   endfunction : clean_byte

   // Byte i holds character i, so the string stays left aligned
   genvar i;
   generate
      for (i = 0; i < `NSC_STR_LEN; i++) begin : g_byte
         assign o_clean[8*i +: 8] = clean_byte(i_raw[8*i +: 8], 4'(i) < i_len);
      end
   endgenerate

endmodule : ascii_pad

// ===== core/storage_ctrl_ns_conventions.sv
// Per-controller convention fields and shared namespace view for a multi-port subsystem
`timescale 1ns/10ps
`include "ns_conv_defines.svh"

module storage_ctrl_ns_conventions (
   // Clock and subsystem reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Per-port resets, one per controller
   input wire logic [`NSC_NPORT-1:0] i_port_rst,
   // Platform values loaded at reset
   input wire logic [`NSC_NPORT-1:0][31:0] i_plat_aqa,
   // Feature support straps
   input wire logic i_set_supported,
   input wire logic i_clear_supported,
   // Field access, one port per controller
   input wire logic [`NSC_NPORT-1:0] i_fld_wr,
   input wire logic [`NSC_NPORT-1:0] i_fld_rd,
   input wire logic [`NSC_NPORT-1:0][1:0] i_fld_sel,
   input wire logic [`NSC_NPORT-1:0][31:0] i_fld_wdata,
   output logic [`NSC_NPORT-1:0][31:0] o_fld_rdata,
   // Hardware status events and set-bit completion
   input wire logic [`NSC_NPORT-1:0][3:0] i_status_evt,
   input wire logic [`NSC_NPORT-1:0][3:0] i_set_done,
   output logic [`NSC_NPORT-1:0][3:0] o_set_req,
   // Namespace handle queries
   input wire logic [31:0] i_ns_count,
   input wire logic [`NSC_NPORT-1:0] i_ns_query,
   input wire logic [`NSC_NPORT-1:0][31:0] i_namespace_handle,
   input wire logic [`NSC_NPORT-1:0][1:0] i_ident_word,
   output logic [`NSC_NPORT-1:0] o_ns_ack,
   output logic [`NSC_NPORT-1:0][1:0] o_ns_kind,
   output logic [`NSC_NPORT-1:0][31:0] o_ident_rdata,
   // Shared identification fill
   input wire logic i_ident_we,
   input wire logic [`NSC_IDENT_AW-1:0] i_ident_waddr,
   input wire logic [31:0] i_ident_wdata,
   // Completion routing
   input wire logic [`NSC_NPORT-1:0][15:0] i_sq_id,
   input wire logic [`NSC_NPORT-1:0][15:0] i_io_cq_id,
   output logic [`NSC_NPORT-1:0][15:0] o_cpl_qid,
   // Write atomicity, zero-based granule per controller
   input wire logic [`NSC_NPORT-1:0][11:0] i_awun,
   output logic [`NSC_NPORT-1:0][12:0] o_atomic_blocks,
   // Decoded sizes
   output logic [`NSC_NPORT-1:0][12:0] o_admin_sq_depth,
   output logic [`NSC_NPORT-1:0][12:0] o_admin_cq_depth,
   output logic [`NSC_NPORT-1:0][17:0] o_page_bytes,
   // Model string
   input wire logic [8*`NSC_STR_LEN-1:0] i_model_raw,
   input wire logic [3:0] i_model_len,
   output logic [8*`NSC_STR_LEN-1:0] o_model_str
);

   ns_conv_pkg::top_state_s st;
   ns_conv_pkg::top_state_s next_st;
   logic [8*`NSC_STR_LEN-1:0] model_clean;
   logic [`NSC_NPORT-1:0] ident_re;
   logic [`NSC_NPORT-1:0][`NSC_IDENT_AW-1:0] ident_raddr;

   // -----------------------------------------------------------------------------
   // Decoding helpers
   // -----------------------------------------------------------------------------
   function automatic logic [1:0] classify(input logic [31:0] h, input logic [31:0] cnt);
      if (h == `NSC_NS_ALL) begin
         classify = ns_conv_pkg::NS_ALL;
      end else if (h == `NSC_NS_NONE || h > cnt || h > `NSC_NS_MAX) begin
         classify = ns_conv_pkg::NS_INVALID;
      end else begin
         classify = ns_conv_pkg::NS_SINGLE;
      end
   endfunction : classify

   // Row 0 holds data common to all namespaces, row n namespace n.
   // The row depends on the handle alone, never on the port.
   function automatic logic [1:0] ns_row(input logic [31:0] h);
      if (h == `NSC_NS_ALL) begin
         ns_row = 2'h0;
      end else begin
         ns_row = h[1:0];
      end
   endfunction : ns_row

   // Zero-based encoding: stored n means n plus one
   function automatic logic [12:0] zero_based(input logic [11:0] v);
      zero_based = {1'b0, v} + 13'h0001;
   endfunction : zero_based

   // -----------------------------------------------------------------------------
   // Field update and read-back
   // -----------------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.model = model_clean;
      for (int p = 0; p < `NSC_NPORT; p++) begin
         next_st.ns_ack[p] = 1'b0;
         next_st.rdata[p] = 32'h0000_0000;
         if (i_srst || i_port_rst[p]) begin
            // On a port reset only this port's slice is touched; memory and peers keep running
            next_st.ctrl[p] = `NSC_CTRL_RST;
            next_st.stat[p] = 32'h0000_0000;
            next_st.aqa[p] = i_plat_aqa[p] & `NSC_AQA_MASK;
            next_st.ns_kind[p] = ns_conv_pkg::NS_INVALID;
            next_st.cpl_qid[p] = `NSC_ADMIN_QID;
            next_st.atomic_blocks[p] = 13'h0001;
         end else begin
            // Set bits drop when hardware finishes, unless set again now
            next_st.ctrl[p] = st.ctrl[p] & ~({20'h00000, i_set_done[p], 8'h00});
            if (i_fld_wr[p]) begin
               case (i_fld_sel[p])
                  ns_conv_pkg::SEL_CTRL: begin
                     // Reserved bits are masked out and never stored
                     next_st.ctrl[p] = (next_st.ctrl[p] & `NSC_CTRL_SET_MASK)
                        | (i_fld_wdata[p] & `NSC_CTRL_RW_MASK);
                     if (i_set_supported) begin
                        next_st.ctrl[p] = next_st.ctrl[p]
                           | (i_fld_wdata[p] & `NSC_CTRL_SET_MASK);
                     end
                  end
                  ns_conv_pkg::SEL_STAT: begin
                     if (i_clear_supported) begin
                        next_st.stat[p] = st.stat[p]
                           & ~(i_fld_wdata[p] & `NSC_STAT_CLR_MASK);
                     end
                  end
                  ns_conv_pkg::SEL_AQA: begin
                     next_st.aqa[p] = i_fld_wdata[p] & `NSC_AQA_MASK;
                  end
                  default: begin
                     // Identity field ignores writes
                  end
               endcase
            end
            // Unsupported clear leaves the status field read-only
            // An event in the clearing cycle survives the clear
            next_st.stat[p] = next_st.stat[p] | {28'h0000000, i_status_evt[p]};
            if (i_fld_rd[p]) begin
               case (i_fld_sel[p])
                  ns_conv_pkg::SEL_CTRL: begin
                     next_st.rdata[p] = st.ctrl[p];
                  end
                  ns_conv_pkg::SEL_STAT: begin
                     next_st.rdata[p] = st.stat[p] & `NSC_STAT_CLR_MASK;
                  end
                  ns_conv_pkg::SEL_AQA: begin
                     next_st.rdata[p] = st.aqa[p];
                  end
                  default: begin
                     // Distinct per controller: port number beside function 0
                     next_st.rdata[p] = {16'h0000, 8'(p), `NSC_PCI_FUNC};
                  end
               endcase
            end
            if (i_ns_query[p]) begin
               next_st.ns_kind[p] = classify(i_namespace_handle[p], i_ns_count);
               next_st.ns_ack[p] = 1'b1;
            end
            // Admin submissions complete only on the admin completion queue
            if (i_sq_id[p] == `NSC_ADMIN_QID) begin
               next_st.cpl_qid[p] = `NSC_ADMIN_QID;
            end else begin
               next_st.cpl_qid[p] = i_io_cq_id[p];
            end
            // Each controller keeps its own granule; no cross-port agreement
            next_st.atomic_blocks[p] = zero_based(i_awun[p]);
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      st <= next_st;
   end

   // -----------------------------------------------------------------------------
   // Shared identification read, issued with the query
   // -----------------------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < `NSC_NPORT; p++) begin
         ident_re[p] = i_ns_query[p] && !i_port_rst[p]
            && (classify(i_namespace_handle[p], i_ns_count) != ns_conv_pkg::NS_INVALID);
         ident_raddr[p] = {ns_row(i_namespace_handle[p]), i_ident_word[p]};
      end
   end

   ns_ident_mem u_ident (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_we(i_ident_we),
      .i_waddr(i_ident_waddr),
      .i_wdata(i_ident_wdata),
      .i_re(ident_re),
      .i_raddr(ident_raddr),
      .o_rdata(o_ident_rdata)
   );

   ascii_pad u_model (
      .i_raw(i_model_raw),
      .i_len(i_model_len),
      .o_clean(model_clean)
   );

   // -----------------------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `NSC_NPORT; g++) begin : g_out
         assign o_set_req[g] = st.ctrl[g][11:8];
         assign o_admin_sq_depth[g] = zero_based(st.aqa[g][11:0]);
         assign o_admin_cq_depth[g] = zero_based(st.aqa[g][`NSC_AQA_CQ_LSB +: 12]);
         // Page size field counts kilobytes of 1024 bytes
         assign o_page_bytes[g] = {st.ctrl[g][7:0], 10'h000};
      end
   endgenerate

   assign o_fld_rdata = st.rdata;
   assign o_ns_ack = st.ns_ack;
   assign o_ns_kind = st.ns_kind;
   assign o_cpl_qid = st.cpl_qid;
   assign o_atomic_blocks = st.atomic_blocks;
   assign o_model_str = st.model;

endmodule : storage_ctrl_ns_conventions

// ===== verification/ns_conv_monitor.sv
// Concurrent checks on the namespace and register-convention block
`timescale 1ns/10ps
`include "ns_conv_defines.svh"

module ns_conv_monitor (
   // Clock and resets
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic [`NSC_NPORT-1:0] i_port_rst,
   input wire logic [`NSC_NPORT-1:0][31:0] i_plat_aqa,
   // Field port
   input wire logic [`NSC_NPORT-1:0] i_fld_wr,
   input wire logic [`NSC_NPORT-1:0] i_fld_rd,
   input wire logic [`NSC_NPORT-1:0][1:0] i_fld_sel,
   input wire logic [`NSC_NPORT-1:0][31:0] o_fld_rdata,
   // Namespace queries
   input wire logic [31:0] i_ns_count,
   input wire logic [`NSC_NPORT-1:0] i_ns_query,
   input wire logic [`NSC_NPORT-1:0][31:0] i_namespace_handle,
   input wire logic [`NSC_NPORT-1:0] o_ns_ack,
   input wire logic [`NSC_NPORT-1:0][1:0] o_ns_kind,
   input wire logic [`NSC_NPORT-1:0][31:0] o_ident_rdata,
   // Routing, sizes and string
   input wire logic [`NSC_NPORT-1:0][15:0] i_sq_id,
   input wire logic [`NSC_NPORT-1:0][15:0] i_io_cq_id,
   input wire logic [`NSC_NPORT-1:0][15:0] o_cpl_qid,
   input wire logic [`NSC_NPORT-1:0][11:0] i_awun,
   input wire logic [`NSC_NPORT-1:0][12:0] o_atomic_blocks,
   input wire logic [`NSC_NPORT-1:0][12:0] o_admin_sq_depth,
   input wire logic [`NSC_NPORT-1:0][17:0] o_page_bytes,
   input wire logic [3:0] i_model_len,
   input wire logic [8*`NSC_STR_LEN-1:0] o_model_str
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);

   for (genvar p = 0; p < 2; p++) begin : g_port
      chk_rd_idle: assert property (!i_fld_rd[p] |=> o_fld_rdata[p] == 32'h0)
         else $error("read data not zero without a read");
      chk_ctrl_rsvd: assert property (i_fld_rd[p] && i_fld_sel[p] == 2'b00 && !i_port_rst[p]
         |=> o_fld_rdata[p][31:12] == 20'h00000) else $error("reserved ctrl bits not zero");
      chk_ns_ack: assert property (!i_port_rst[p] |=> o_ns_ack[p] == $past(i_ns_query[p]))
         else $error("query acknowledge misplaced");
      chk_ns_all: assert property (i_ns_query[p] && !i_port_rst[p]
         && i_namespace_handle[p] == 32'hFFFF_FFFF |=> o_ns_kind[p] == 2'b10)
         else $error("all-ones handle not reported as all");
      chk_ns_invalid: assert property (i_ns_query[p] && !i_port_rst[p]
         && (i_namespace_handle[p] == 32'h0 || (i_namespace_handle[p] != 32'hFFFF_FFFF
         && (i_namespace_handle[p] > i_ns_count || i_namespace_handle[p] > 32'h3)))
         |=> o_ns_kind[p] == 2'b00 && o_ident_rdata[p] == 32'h0)
         else $error("invalid handle accepted");
      chk_cpl_route: assert property (!i_port_rst[p] |=> o_cpl_qid[p] ==
         (($past(i_sq_id[p]) == 16'h0) ? 16'h0 : $past(i_io_cq_id[p])))
         else $error("completion sent to wrong queue");
      chk_atomic_gran: assert property (!i_port_rst[p]
         |=> o_atomic_blocks[p] == {1'b0, $past(i_awun[p])} + 13'h0001)
         else $error("atomic granule not value plus one");
      chk_page_kb: assert property (i_fld_rd[p] && !i_fld_wr[p] && i_fld_sel[p] == 2'b00
         && !i_port_rst[p] |=> o_page_bytes[p] == {o_fld_rdata[p][7:0], 10'h000})
         else $error("page size not in 1024 byte units");
      chk_aqa_load: assert property (i_port_rst[p]
         |=> o_admin_sq_depth[p] == {1'b0, i_plat_aqa[p][11:0]} + 13'h0001)
         else $error("platform queue size not loaded");
      chk_port_iso: assert property (i_port_rst[p] && !i_port_rst[1-p] && !i_fld_wr[1-p]
         |=> $stable(o_admin_sq_depth[1-p])) else $error("port reset disturbed other port");
   end

   for (genvar b = 0; b < 8; b++) begin : g_byte
      chk_str_pad: assert property (i_model_len <= b |=> o_model_str[8*b +: 8] == 8'h20)
         else $error("string tail not padded with spaces");
      chk_str_print: assert property (o_model_str[8*b +: 8] >= 8'h20
         && o_model_str[8*b +: 8] <= 8'h7E) else $error("string byte not printable");
   end
endmodule : ns_conv_monitor

bind storage_ctrl_ns_conventions ns_conv_monitor u_mon (.*);

// ===== verification/ns_host_model.sv
// Platform side model: boot values and fill of the shared identify store
`timescale 1ns/10ps
`include "ns_conv_defines.svh"

module ns_host_model (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Boot values and store fill
   output logic [`NSC_NPORT-1:0][31:0] o_plat_aqa,
   output logic o_ident_we,
   output logic [`NSC_IDENT_AW-1:0] o_ident_waddr,
   output logic [31:0] o_ident_wdata,
   output logic o_fill_done
);
   logic [4:0] cnt;

   // Firmware keeps reserved bits of boot values at zero
   assign o_plat_aqa[0] = 32'h0013_0007;
   assign o_plat_aqa[1] = 32'h0020_0003;
   assign o_fill_done = cnt[4] & ~o_ident_we;

   // Store is filled once; later resets must not need a refill
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         cnt <= 5'h00;
         o_ident_we <= 1'b0;
         o_ident_waddr <= 4'h0;
         o_ident_wdata <= 32'h0;
      end else if (!cnt[4]) begin
         cnt <= cnt + 5'h01;
         o_ident_we <= 1'b1;
         o_ident_waddr <= cnt[3:0];
         o_ident_wdata <= {28'h5A00000, cnt[3:0]};
      end else begin
         // Idle lines toggle so a stale value never looks like a write
         o_ident_we <= 1'b0;
         o_ident_waddr <= ~o_ident_waddr;
         o_ident_wdata <= ~o_ident_wdata;
      end
   end
endmodule : ns_host_model

// ===== verification/tb_top.sv
// Self-checking bench for the namespace and register-convention block
`timescale 1ns/10ps

module tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] prst = '0, wr = '0, rd = '0, nsq = '0, ack, rd_d, nsq_d;
   logic set_sup = 1'b1, clr_sup = 1'b1, iwe, fill_done;
   logic [1:0][1:0] sel = '0, word = '0, kind;
   logic [1:0][31:0] wdata = '0, rdata, hnd = '0, idat, plat;
   logic [1:0][3:0] evt = '0, done = '0, set_req;
   logic [31:0] ns_count = 32'h2, d, iwd;
   logic [1:0][15:0] sqid = '0, cqid = '0, cpl;
   logic [1:0][11:0] awun = '0;
   logic [1:0][12:0] ablk, sqd, cqd;
   logic [1:0][17:0] pgb;
   logic [3:0] iwa, mlen = '0;
   logic [63:0] mraw = '0, mstr;
   logic [33:0] e, en;
   logic [31:0] fq [2][$];
   logic [33:0] nq [2][$];
   logic [31:0] hl [6] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'hFFFF_FFFF};
   int err_total = 0, tests_run = 0, cyc = 0;

   always #2.5 clk = ~clk;

   storage_ctrl_ns_conventions uut (.i_core_clk(clk), .i_srst(srst), .i_port_rst(prst),
      .i_plat_aqa(plat), .i_set_supported(set_sup), .i_clear_supported(clr_sup),
      .i_fld_wr(wr), .i_fld_rd(rd), .i_fld_sel(sel), .i_fld_wdata(wdata), .o_fld_rdata(rdata),
      .i_status_evt(evt), .i_set_done(done), .o_set_req(set_req), .i_ns_count(ns_count),
      .i_ns_query(nsq), .i_namespace_handle(hnd), .i_ident_word(word), .o_ns_ack(ack),
      .o_ns_kind(kind), .o_ident_rdata(idat), .i_ident_we(iwe), .i_ident_waddr(iwa),
      .i_ident_wdata(iwd), .i_sq_id(sqid), .i_io_cq_id(cqid), .o_cpl_qid(cpl), .i_awun(awun),
      .o_atomic_blocks(ablk), .o_admin_sq_depth(sqd), .o_admin_cq_depth(cqd),
      .o_page_bytes(pgb), .i_model_raw(mraw), .i_model_len(mlen), .o_model_str(mstr));

   ns_host_model u_host (.i_core_clk(clk), .i_srst(srst), .o_plat_aqa(plat), .o_ident_we(iwe),
      .o_ident_waddr(iwa), .o_ident_wdata(iwd), .o_fill_done(fill_done));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   always @(posedge clk) begin
      rd_d <= rd & ~prst & {2{~srst}};
      nsq_d <= nsq & ~prst;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         report_and_stop();
      end
   end

   // Results are compared half a cycle after they land
   always @(negedge clk) begin
      for (int p = 0; p < 2; p++) begin
         if (rd_d[p]) check("field", rdata[p], fq[p].pop_front());
         if (nsq_d[p]) begin
            en = nq[p].pop_front();
            check("kind", kind[p], en[33:32]);
            check("ident", idat[p], en[31:0]);
         end
      end
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task fld(input int p, input logic w, input logic [1:0] s, input logic [31:0] v);
      @(posedge clk);
      wr[p] <= w;
      rd[p] <= ~w;
      sel[p] <= s;
      wdata[p] <= v;
      if (!w) fq[p].push_back(v);
      @(posedge clk);
      wr[p] <= 1'b0;
      rd[p] <= 1'b0;
   endtask : fld

   task nsk(input logic [31:0] h, input logic [1:0] w);
      logic [1:0] k;
      // Formed at the edge, so a count changed just before the call is already seen
      @(posedge clk);
      k = (h == 32'hFFFF_FFFF) ? 2'h2 : (h == 32'h0 || h > ns_count || h > 32'h3) ? 2'h0 : 2'h1;
      e = {k, (k == 2'h0) ? 32'h0 : {28'h5A00000, (k == 2'h2) ? 2'h0 : h[1:0], w}};
      nsq <= 2'h3;
      hnd <= {h, h};
      word <= {w, w};
      nq[0].push_back(e);
      nq[1].push_back(e);
      @(posedge clk);
      nsq <= 2'h0;
   endtask : nsk

   initial begin
      void'($urandom(32'h8E08D813));
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      while (!fill_done) @(posedge clk);
      for (int p = 0; p < 2; p++) begin
         fld(p, 0, 2'h0, 32'h0000_0004);
         fld(p, 0, 2'h2, plat[p] & 32'h0FFF_0FFF);
         fld(p, 1, 2'h3, 32'hFFFF_FFFF);
         fld(p, 0, 2'h3, {16'h0, p[7:0], 8'h00});
      end
      fld(0, 1, 2'h0, 32'hFFFF_FFFF);
      fld(0, 0, 2'h0, 32'h0000_0FFF);
      #1 check("set_req", set_req[0], 4'hF);
      check("page", pgb[0], 18'h3FC00);
      fld(0, 1, 2'h0, 32'h0);
      fld(0, 0, 2'h0, 32'h0000_0F00);
      done[0] <= 4'h5;
      @(posedge clk);
      done[0] <= 4'h0;
      fld(0, 0, 2'h0, 32'h0000_0A00);
      set_sup <= 1'b0;
      fld(0, 1, 2'h0, 32'hFFFF_FFFF);
      fld(0, 0, 2'h0, 32'h0000_0AFF);
      evt[0] <= 4'hF;
      @(posedge clk);
      evt[0] <= 4'h0;
      fld(0, 1, 2'h1, 32'h1);
      fld(0, 1, 2'h1, 32'h0);
      fld(0, 0, 2'h1, 32'hE);
      clr_sup <= 1'b0;
      fld(0, 1, 2'h1, 32'hF);
      fld(0, 0, 2'h1, 32'hE);
      clr_sup <= 1'b1;
      fld(0, 1, 2'h1, 32'hF);
      fld(0, 0, 2'h1, 32'h0);
      for (int i = 0; i < 4; i++) begin
         d = $urandom();
         fld(1, 1, 2'h2, d);
         fld(1, 0, 2'h2, d & 32'h0FFF_0FFF);
         #1 check("cq_depth", cqd[1], {1'b0, d[27:16]} + 13'h0001);
      end
      // Port 0 reset while port 1 keeps its state; host orders the two ports itself
      fld(1, 1, 2'h0, 32'h0000_0012);
      fld(0, 1, 2'h0, 32'h0000_0033);
      prst[0] <= 1'b1;
      repeat (2) @(posedge clk);
      prst[0] <= 1'b0;
      fld(0, 0, 2'h0, 32'h0000_0004);
      fld(1, 0, 2'h0, 32'h0000_0012);
      foreach (hl[i]) for (int w = 0; w < 4; w++) nsk(hl[i], w[1:0]);
      ns_count <= 32'h3;
      nsk(32'h3, 2'h1);
      for (int i = 0; i < 40; i++) begin
         d = $urandom();
         @(posedge clk);
         sqid <= {d[15:0] & 16'h0003, d[31:16] & 16'h0003};
         cqid <= {d[31:16], d[15:0]};
         awun <= {d[11:0], d[27:16]};
         mraw <= {d, d ^ 32'h5555_AAAA};
         mlen <= d[3:0];
      end
      @(posedge clk);
      mraw <= 64'h0000_0000_0001_4241;
      mlen <= 4'h4;
      repeat (2) @(posedge clk);
      #1 check("model", mstr, 64'h2020_2020_2020_4241);
      report_and_stop();
   end
endmodule : tb_top
